// file: src/hwl_pkg.sv
// package of the halfword/word load execution block
// assumes one core clock; shared by the block and its bench
package hwl_pkg;

    // ==========================================================
    // instruction encodings
    localparam logic [5:0] OP_LHU_RR = 6'h31;
    localparam logic [5:0] OP_LHU_IM = 6'h39;
    localparam logic [5:0] OP_LW_RR  = 6'h32;
    localparam logic [5:0] OP_LW_IM  = 6'h3a;
    localparam int FN_REV_BIT = 9;
    localparam int FN_EA_BIT  = 7;

    // ==========================================================
    // exception cause codes
    localparam logic [4:0] EC_TLB_MISS = 5'h12;
    localparam logic [4:0] EC_STORAGE  = 5'h10;
    localparam logic [4:0] EC_UNALIGN  = 5'h01;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_MSTAT  = 12'h004;
    localparam logic [11:0] OFS_XSTAT  = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;

    // ==========================================================
    // field positions
    localparam int CTRL_PAE   = 0;
    localparam int CTRL_EAOK  = 1;
    localparam int MS_UM      = 0;
    localparam int MS_VM      = 1;
    localparam int MS_UMS     = 2;
    localparam int MS_VMS     = 3;
    localparam int XS_EC_LSB  = 0;
    localparam int XS_S       = 5;
    localparam int XS_W       = 6;
    localparam int XS_DIZ     = 7;
    localparam int XS_RX_LSB  = 8;

    // ==========================================================
    // reset values
    localparam logic [1:0]  CTRL_RST  = 2'h0;
    localparam logic [3:0]  MSTAT_RST = 4'h0;
    localparam logic [12:0] XSTAT_RST = 13'h0000;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_CHECK = 2'b01,
        S_MEM   = 2'b10,
        S_HOLD  = 2'b11
    } hwl_state_t;

    // raw instruction word, field order as issued by the core
    typedef struct packed {
        logic [5:0]  op;
        logic [4:0]  rd;
        logic [4:0]  ra;
        logic [4:0]  rb;
        logic [10:0] fn;
    } hwl_inst_t;

    // answer from address translation for the presented address
    typedef struct packed {
        logic miss;
        logic noAccess;
        logic endian;
    } hwl_xlat_t;

endpackage

// file: src/hwl_load_exec.sv
// halfword unsigned and word load execution with exception checks
// assumes translation answers combinationally to xlatAddr while
// xlatReq is high, and memory answers memReq with one memRvalid
// Operation
// [RL1] register halfword load: rA+rB address, 16 bits zero-extended into destination
// [RL2] reverse bit: halfword-reversed location and bytes exchanged
// [RL3] extended-address bit: address is rA concatenated with rB
// [RL4] translation miss in virtual mode: cause 10010, save and clear mode flags
// [RL5] user+virtual no-access zone: cause 10000, zone flag, save and clear flags
// [RL6] odd halfword address: cause 00001, word flag 0, record destination
// [RL7] word address low bits nonzero: cause 00001, word flag 1, record destination
// [RL8] check order: miss, then protection, then alignment; write only if none
// [RL9] destination untouched on exception; mode flags only on miss or protection
// [RL10] halfword byte placement by virtual mode, reverse bit and endian
// [RL11] immediate halfword load: rA plus sign-extended immediate, same checks
// [RL12] word load: 32 bits low, upper word cleared on 64-bit data
// [RL13] reverse bit on word load reverses the loaded bytes
// [RL14] privileged error: extended address, extension on, not permitted
// [RL15] one cycle for area setting 0 or 2, two cycles for 1
// [RL16] immediate sign-extended unless a prefix directly precedes
// [RL17] reversed variants valid only with reorder enable set
// [RL18] extended-address variants need address width above 32, data 32
// [RL19] immediate word load: rA plus immediate, word alignment and checks
// [RL20] prefix supplies upper 16 immediate bits, load field the lower 16
// [RL21] no memory read issued for a load that faults
`timescale 1ns/1ns
`default_nettype none
module hwl_load_exec
    import hwl_pkg::*;
#(
    parameter int ADDR_W               = 32,
    parameter int DATA_W               = 32,
    parameter int AREA_OPT             = 0,
    parameter bit reorder_enable_param = 1'b1
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // instruction issue
    input  wire logic              instValid,
    input  wire hwl_inst_t         instWord,
    input  wire logic [DATA_W-1:0] opA,
    input  wire logic [DATA_W-1:0] opB,
    input  wire logic              immPrefixValid,
    input  wire logic [15:0]       immPrefixHi,
    output logic                   instReady,
    // translation
    output logic                   xlatReq,
    output logic [ADDR_W-1:0]      xlatAddr,
    input  wire hwl_xlat_t         xlatAns,
    // memory read
    output logic                   memReq,
    output logic [ADDR_W-1:0]      memAddr,
    output logic                   memWord,
    input  wire logic              memRvalid,
    input  wire logic [31:0]       memRdata,
    // results
    output logic                   wbValid,
    output logic [4:0]             wbReg,
    output logic [DATA_W-1:0]      wbData,
    output logic                   excValid,
    output logic                   privErr,
    output logic                   illegalInst
);

    // ==========================================================
    // reset release
    logic rstMeta_q;
    logic rstSync_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    wire logic rstN = rstSync_q;

    // ==========================================================
    // decode and address formation
    localparam bit EA_LEGAL = (ADDR_W > 32) && (DATA_W == 32);
    hwl_state_t state_q;
    logic [1:0]  ctrl_q;
    logic [3:0]  mstat_q;
    logic [12:0] xstat_q;

    wire logic isHalf = (instWord.op == OP_LHU_RR) || (instWord.op == OP_LHU_IM);
    wire logic isWord = (instWord.op == OP_LW_RR) || (instWord.op == OP_LW_IM);
    wire logic isImm  = (instWord.op == OP_LHU_IM) || (instWord.op == OP_LW_IM);
    wire logic revBit = !isImm && instWord.fn[FN_REV_BIT];
    wire logic eaBit  = !isImm && instWord.fn[FN_EA_BIT];
    wire logic badVariant = !(isHalf || isWord)
                          || (revBit && !reorder_enable_param)     // RL17
                          || (eaBit && !EA_LEGAL);                 // RL18
    wire logic privHit = eaBit && ctrl_q[CTRL_PAE] && !ctrl_q[CTRL_EAOK]; // RL14
    wire logic take    = instValid && instReady;

    logic [15:0] imm16;
    logic [31:0] imm32;
    logic [63:0] addrFull;
    always_comb begin
        imm16 = {instWord.rb, instWord.fn};
        // a prefix must be the directly preceding instruction
        imm32 = immPrefixValid ? {immPrefixHi, imm16}                 // RL20
                               : {{16{imm16[15]}}, imm16};            // RL16
        if (isImm) begin
            addrFull = 64'(opA) + {{32{imm32[31]}}, imm32};          // RL11 RL19
        end else if (eaBit) begin
            addrFull = {32'(opA), 32'(opB)};                         // RL3
        end else begin
            addrFull = 64'(opA) + 64'(opB);                          // RL1
        end
        if (revBit && isHalf) begin
            addrFull = addrFull ^ 64'h0000_0000_0000_0002;           // RL2
        end
    end

    // ==========================================================
    // captured operation
    logic              opWord_q;
    logic              opRev_q;
    logic [4:0]        opRd_q;
    logic [ADDR_W-1:0] addr_q;
    logic              endian_q;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            opWord_q <= 1'b0;
            opRev_q  <= 1'b0;
            opRd_q   <= 5'h00;
            addr_q   <= '0;
        end else if (take) begin
            opWord_q <= isWord;
            opRev_q  <= revBit;
            opRd_q   <= instWord.rd;
            addr_q   <= addrFull[ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            endian_q <= 1'b0;
        end else if (state_q == S_CHECK) begin
            endian_q <= xlatAns.endian;
        end
    end

    // ==========================================================
    // exception classification, priority fixed
    wire logic vmOn     = mstat_q[MS_VM];
    wire logic umOn     = mstat_q[MS_UM];
    wire logic missHit  = xlatAns.miss && vmOn;                       // RL4
    wire logic protHit  = !missHit && xlatAns.noAccess && umOn && vmOn; // RL5 RL8
    wire logic alignBad = opWord_q ? (addr_q[1:0] != 2'b00)          // RL7
                                   : addr_q[0];                      // RL6
    wire logic alignHit = !missHit && !protHit && alignBad;           // RL8
    wire logic checking = (state_q == S_CHECK);
    wire logic anyFault = checking && (missHit || protHit || alignHit);

    // ==========================================================
    // sequencing
    logic [DATA_W-1:0] loadData;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (take && !badVariant && !privHit) begin
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    state_q <= anyFault ? S_IDLE : S_MEM;
                end
                S_MEM: begin
                    if (memRvalid) begin
                        // area setting 1 spends an extra cycle
                        state_q <= (AREA_OPT == 1) ? S_HOLD : S_IDLE; // RL15
                    end
                end
                S_HOLD: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            instReady   <= 1'b0;
            xlatReq     <= 1'b0;
            xlatAddr    <= '0;
            privErr     <= 1'b0;
            illegalInst <= 1'b0;
        end else begin
            instReady   <= (state_q == S_IDLE) ? !(take && !badVariant && !privHit)
                         : (checking && anyFault)
                         || (state_q == S_MEM && memRvalid && AREA_OPT != 1)
                         || (state_q == S_HOLD);
            xlatReq     <= take && !badVariant && !privHit;
            xlatAddr    <= take ? addrFull[ADDR_W-1:0] : xlatAddr;
            privErr     <= take && !badVariant && privHit;       // RL14
            illegalInst <= take && badVariant;                   // RL17 RL18
        end
    end

    // memory read only once all checks pass
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            memReq  <= 1'b0;
            memAddr <= '0;
            memWord <= 1'b0;
        end else begin
            memReq  <= checking && !anyFault;                    // RL21
            memAddr <= (checking && !anyFault) ? addr_q : memAddr;
            memWord <= (checking && !anyFault) ? opWord_q : memWord;
        end
    end

    // ==========================================================
    // data formatting; rdata lane k holds the byte at address+k
    logic upperFirst;
    always_comb begin
        upperFirst = (!vmOn && opRev_q) || (vmOn && (opRev_q == endian_q)); // RL10
        loadData   = '0;
        if (opWord_q) begin
            loadData[31:0] = opRev_q ? {memRdata[7:0], memRdata[15:8],
                                        memRdata[23:16], memRdata[31:24]} // RL13
                                     : memRdata;                          // RL12
        end else begin
            loadData[15:0] = upperFirst ? {memRdata[7:0], memRdata[15:8]}
                                        : {memRdata[15:8], memRdata[7:0]}; // RL1
        end
    end

    logic [DATA_W-1:0] hold_q;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wbValid <= 1'b0;
            wbReg   <= 5'h00;
            wbData  <= '0;
            hold_q  <= '0;
        end else begin
            hold_q  <= (state_q == S_MEM && memRvalid) ? loadData : hold_q;
            wbValid <= (state_q == S_MEM && memRvalid && AREA_OPT != 1)
                    || (state_q == S_HOLD);                            // RL9 RL15
            wbReg   <= opRd_q;
            if (state_q == S_MEM && memRvalid && AREA_OPT != 1) begin
                wbData <= loadData;
            end else if (state_q == S_HOLD) begin
                wbData <= hold_q;
            end
        end
    end

    // ==========================================================
    // apb slave; hardware updates win over a software write
    wire logic apbAcc = psel && penable && pready;
    wire logic apbWr  = apbAcc && pwrite;
    wire logic mapped = (paddr == OFS_CTRL) || (paddr == OFS_MSTAT)
                     || (paddr == OFS_XSTAT) || (paddr == OFS_STATUS);

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            unique case (paddr)
                OFS_CTRL:   prdata <= 32'(ctrl_q);
                OFS_MSTAT:  prdata <= 32'(mstat_q);
                OFS_XSTAT:  prdata <= 32'(xstat_q);
                OFS_STATUS: prdata <= 32'(state_q);
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ctrl_q <= CTRL_RST;
        end else if (apbWr && paddr == OFS_CTRL) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            mstat_q <= MSTAT_RST;
        end else if (checking && (missHit || protHit)) begin
            mstat_q[MS_UMS] <= umOn;                                   // RL4 RL5
            mstat_q[MS_VMS] <= vmOn;
            mstat_q[MS_UM]  <= 1'b0;
            mstat_q[MS_VM]  <= 1'b0;
        end else if (apbWr && paddr == OFS_MSTAT) begin
            mstat_q <= pwdata[3:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            xstat_q <= XSTAT_RST;
        end else if (checking && missHit) begin
            xstat_q[XS_EC_LSB +: 5] <= EC_TLB_MISS;                    // RL4
            xstat_q[XS_S]           <= 1'b0;
        end else if (checking && protHit) begin
            xstat_q[XS_EC_LSB +: 5] <= EC_STORAGE;                     // RL5
            xstat_q[XS_S]           <= 1'b0;
            xstat_q[XS_DIZ]         <= 1'b1;
        end else if (checking && alignHit) begin
            xstat_q[XS_EC_LSB +: 5] <= EC_UNALIGN;                     // RL6 RL7
            xstat_q[XS_W]           <= opWord_q;
            xstat_q[XS_S]           <= 1'b0;
            xstat_q[XS_RX_LSB +: 5] <= opRd_q;
        end else if (apbWr && paddr == OFS_XSTAT) begin
            xstat_q <= pwdata[12:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            excValid <= 1'b0;
        end else begin
            excValid <= anyFault;                                      // RL8
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    property p_miss_code;
        checking && missHit |=> xstat_q[4:0] == EC_TLB_MISS && !mstat_q[MS_VM];
    endproperty
    a_miss_code: assert property (p_miss_code) else $error("miss code wrong"); // RL4

    property p_prot_code;
        checking && protHit |=> xstat_q[4:0] == EC_STORAGE && xstat_q[XS_DIZ]
                                && !mstat_q[MS_UM] && $past(umOn) == mstat_q[MS_UMS];
    endproperty
    a_prot_code: assert property (p_prot_code) else $error("storage code wrong"); // RL5

    property p_align_half;
        checking && alignHit && !opWord_q |=> xstat_q[4:0] == EC_UNALIGN
                                && !xstat_q[XS_W] && xstat_q[12:8] == $past(opRd_q);
    endproperty
    a_align_half: assert property (p_align_half) else $error("half align wrong"); // RL6

    property p_align_word;
        checking && alignHit && opWord_q |=> xstat_q[4:0] == EC_UNALIGN && xstat_q[XS_W];
    endproperty
    a_align_word: assert property (p_align_word) else $error("word align wrong"); // RL7

    property p_no_req_on_fault;
        anyFault |=> !memReq ##1 !memReq && !wbValid;
    endproperty
    a_no_req_on_fault: assert property (p_no_req_on_fault) else $error("read after fault"); // RL21

    property p_mstat_kept_align;
        checking && alignHit |=> $stable(mstat_q);
    endproperty
    a_mstat_kept_align: assert property (p_mstat_kept_align) else $error("flags changed"); // RL9

    property p_wb_latency;
        state_q == S_MEM && memRvalid |-> ##((AREA_OPT == 1) ? 2 : 1) wbValid;
    endproperty
    a_wb_latency: assert property (p_wb_latency) else $error("writeback latency"); // RL15

    property p_priv;
        take && !badVariant && privHit |=> privErr && !xlatReq ##1 !memReq;
    endproperty
    a_priv: assert property (p_priv) else $error("privilege not flagged"); // RL14

    property p_upper_clear;
        wbValid |-> wbData[DATA_W-1:16] == '0 || $past(opWord_q, 2)
                    || $past(opWord_q, 3);
    endproperty
    a_upper_clear: assert property (p_upper_clear) else $error("upper bits set"); // RL1

    c_load_done:  cover property (memReq ##[1:20] wbValid);
    c_miss:       cover property (checking && missHit);
    c_prot:       cover property (checking && protHit);
    c_align_word: cover property (checking && alignHit && opWord_q);

endmodule
`default_nettype wire

// file: sim/hwl_mem_model.sv
// partner model: address translation answer and data memory
// assumes one read outstanding; answers in 2 or 4 cycles by slow
`timescale 1ns/1ns
`default_nettype none
module hwl_mem_model
    import hwl_pkg::*;
#(
    parameter int AW = 64
) (
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    input  wire logic          xlatReq,
    input  wire hwl_xlat_t     cfg,
    input  wire logic          slow,
    output hwl_xlat_t          xlatAns,
    input  wire logic          memReq,
    input  wire logic [AW-1:0] memAddr,
    output logic               memRvalid,
    output logic [31:0]        memRdata
);
    logic [1:0] cnt_q;
    logic [7:0] base;
    // ==========================================================
    // answer
    // valid only while asked; inverted otherwise so a stale answer never passes
    assign xlatAns = xlatReq ? cfg : ~cfg;
    assign base    = memAddr[7:0] ^ memAddr[23:16];
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q     <= 2'h0;
            memRvalid <= 1'b0;
            memRdata  <= 32'h0;
        end else begin
            memRvalid <= 1'b0;
            memRdata  <= ~memRdata;
            if (memReq) begin
                cnt_q <= slow ? 2'h3 : 2'h1;
            end else if (cnt_q != 2'h0) begin
                cnt_q <= cnt_q - 2'h1;
            end
            if (cnt_q == 2'h1) begin
                memRvalid <= 1'b1;
                // lane k holds the byte at address+k
                memRdata  <= {base + 8'h3, base + 8'h2, base + 8'h1, base};
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/halfword_word_load_exec_tb.sv
// testbench of the load execution block: row table, then hand cases
// assumes the partner model answers translation and memory reads
`timescale 1ns/1ns
`default_nettype none
module halfword_word_load_exec_tb
    import hwl_pkg::*;
;
    typedef struct packed {
        logic [5:0] op; logic [4:0] rd, rb; logic [10:0] fn; logic [31:0] a, b;
        logic pv; logic [3:0] ms; hwl_xlat_t xl; logic wb; logic [31:0] dat;
        logic [12:0] xs; logic [3:0] msx;
    } hwl_row_t;
    logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, opA, opB, memRdata, wbData, rdat, gData;
    logic        instValid, immPrefixValid, instReady, xlatReq, memReq, memWord;
    logic        memRvalid, wbValid, excValid, privErr, illegalInst, slow, er;
    logic        gWb, gExc, gPriv, gIll, gWord;
    logic [4:0]  wbReg, gReg;
    logic [63:0] xlatAddr, memAddr, gAddr;
    hwl_inst_t   instWord;
    hwl_xlat_t   xlatAns, cfg;
    hwl_row_t    r;
    int          n_errors = 0, checks_done = 0, cyc = 0, nReq, tRv, tWb;
    // ==========================================================
    // ordinary cases: op rd rb fn a b prefix mstat xlat wb data xstat mstat_after
    hwl_row_t rows [13] = '{
        '{OP_LHU_RR, 5'd1, 5'd0, 11'h0, 32'h100, 32'h4, 1'b0, 4'h0, 3'h0, 1'b1, 32'h504, 13'h0, 4'h0},
        '{OP_LHU_RR, 5'd2, 5'd0, 11'h200, 32'h100, 32'h4, 1'b0, 4'h0, 3'h0, 1'b1, 32'h607, 13'h0, 4'h0},
        '{OP_LHU_IM, 5'd3, 5'h1f, 11'h7fe, 32'h200, 32'h0, 1'b0, 4'h2, 3'h1, 1'b1, 32'hfffe, 13'h0, 4'h2},
        '{OP_LW_RR, 5'd4, 5'd0, 11'h0, 32'h100, 32'h8, 1'b0, 4'h0, 3'h0, 1'b1, 32'h0b0a_0908, 13'h0, 4'h0},
        '{OP_LW_RR, 5'd5, 5'd0, 11'h200, 32'h100, 32'h8, 1'b0, 4'h0, 3'h0, 1'b1, 32'h0809_0a0b, 13'h0, 4'h0},
        '{OP_LW_IM, 5'd6, 5'h10, 11'h010, 32'h100, 32'h0, 1'b1, 4'h0, 3'h0, 1'b1, 32'h1413_1211, 13'h0, 4'h0},
        '{OP_LHU_RR, 5'd7, 5'd0, 11'h0, 32'h100, 32'h1, 1'b0, 4'h2, 3'h0, 1'b0, 32'h0, 13'h0701, 4'h2},
        '{OP_LW_IM, 5'd9, 5'd0, 11'h002, 32'h100, 32'h0, 1'b0, 4'h0, 3'h0, 1'b0, 32'h0, 13'h0941, 4'h0},
        '{OP_LHU_RR, 5'd10, 5'd0, 11'h0, 32'h100, 32'h1, 1'b0, 4'h3, 3'h6, 1'b0, 32'h0, 13'h0012, 4'hc},
        '{OP_LHU_RR, 5'd11, 5'd0, 11'h0, 32'h101, 32'h0, 1'b0, 4'h3, 3'h2, 1'b0, 32'h0, 13'h0090, 4'hc},
        '{OP_LHU_RR, 5'd12, 5'd0, 11'h0, 32'h120, 32'h0, 1'b0, 4'h2, 3'h2, 1'b1, 32'h2021, 13'h0, 4'h2},
        '{OP_LW_RR, 5'd13, 5'd0, 11'h0, 32'h130, 32'h0, 1'b0, 4'h0, 3'h4, 1'b1, 32'h3332_3130, 13'h0, 4'h0},
        '{OP_LHU_RR, 5'd14, 5'd0, 11'h200, 32'h140, 32'h0, 1'b0, 4'h2, 3'h1, 1'b1, 32'h4243, 13'h0, 4'h2}
    };
    hwl_load_exec #(.ADDR_W(64), .AREA_OPT(0), .reorder_enable_param(1'b1)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instValid(instValid), .instWord(instWord), .opA(opA), .opB(opB),
        .immPrefixValid(immPrefixValid), .immPrefixHi(16'h0001), .instReady(instReady),
        .xlatReq(xlatReq), .xlatAddr(xlatAddr), .xlatAns(xlatAns), .memReq(memReq),
        .memAddr(memAddr), .memWord(memWord), .memRvalid(memRvalid), .memRdata(memRdata),
        .wbValid(wbValid), .wbReg(wbReg), .wbData(wbData), .excValid(excValid),
        .privErr(privErr), .illegalInst(illegalInst));
    hwl_mem_model #(.AW(64)) partner (.clk_sys(clk_sys), .reset_n(reset_n), .xlatReq(xlatReq),
        .cfg(cfg), .slow(slow), .xlatAns(xlatAns), .memReq(memReq), .memAddr(memAddr),
        .memRvalid(memRvalid), .memRdata(memRdata));
    // ==========================================================
    // clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end
    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata;
        er   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // issue one load and watch its outcome until the block is ready again
    task automatic issue(input hwl_inst_t w, input logic [31:0] a, b, input logic pv);
        int i;
        {gWb, gExc, gPriv, gIll, nReq, tRv, tWb} = '0;
        while (instReady !== 1'b1) @(posedge clk_sys);
        instValid      <= 1'b1;
        instWord       <= w;
        opA            <= a;
        opB            <= b;
        immPrefixValid <= pv;
        @(posedge clk_sys);
        instValid      <= 1'b0;
        immPrefixValid <= 1'b0;
        for (i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            if (memReq) begin
                nReq++;
                gAddr = memAddr;
                gWord = memWord;
            end
            if (memRvalid) tRv = i;
            if (wbValid) begin
                {gWb, tWb, gData, gReg} = {1'b1, i, wbData, wbReg};
            end
            gExc  |= excValid;
            gPriv |= privErr;
            gIll  |= illegalInst;
            if ((gWb | gExc | gPriv | gIll) && instReady) break;
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, instValid, instWord} = '0;
        {opA, opB, immPrefixValid, cfg, slow} = '0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(1'b0, OFS_MSTAT, 32'h0);
        chk("mstat reset", rdat, MSTAT_RST);
        apb(1'b0, OFS_XSTAT, 32'h0);
        chk("xstat reset", rdat, XSTAT_RST);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", er, 1'b1);
        foreach (rows[k]) begin
            r = rows[k];
            apb(1'b1, OFS_MSTAT, {28'h0, r.ms});
            apb(1'b1, OFS_XSTAT, 32'h0);
            cfg  <= r.xl;
            slow <= k[0];
            issue({r.op, r.rd, 5'h0, r.rb, r.fn}, r.a, r.b, r.pv);
            chk("wb", gWb, r.wb);
            chk("exc", gExc, !r.wb);
            chk("reads", nReq, r.wb);
            if (r.wb) begin
                chk("data", gData, r.dat);
                chk("reg", gReg, r.rd);
                chk("word", gWord, r.op[1]);
                chk("latency", tWb - tRv, 1);
            end
            apb(1'b0, OFS_XSTAT, 32'h0);
            chk("xstat", rdat, r.xs);
            apb(1'b0, OFS_MSTAT, 32'h0);
            chk("mstat", rdat, r.msx);
        end
        // unknown opcode, then extended address refused and then permitted
        issue({6'h00, 26'h0}, 32'h0, 32'h0, 1'b0);
        chk("illegal", gIll, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_MSTAT, 32'h0);
        cfg <= '0;
        issue({OP_LW_RR, 5'd2, 10'h0, 11'h080}, 32'h1, 32'h140, 1'b0);
        chk("priv", gPriv, 1'b1);
        chk("priv reads", nReq, 0);
        apb(1'b1, OFS_CTRL, 32'h3);
        issue({OP_LW_RR, 5'd2, 10'h0, 11'h080}, 32'h1, 32'h140, 1'b0);
        chk("ea addr", gAddr, 64'h0000_0001_0000_0140);
        chk("ea xlat", xlatAddr, 64'h0000_0001_0000_0140);
        chk("ea data", gData, 32'h4342_4140);
        close_out();
    end
endmodule
`default_nettype wire
